/* bench/acmd_exec_monitor.sv */
`timescale 1ns/10ps
module acmd_exec_monitor (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// watched ports
	input wire logic byte_vld_i,
	input wire logic reply_vld_o,
	input wire acmd_pkg::acmd_reply_t reply_o,
	input wire logic axis_wr_o,
	input wire acmd_pkg::acmd_param_wr_t axis_wr_data_o,
	input wire logic glob_wr_o,
	input wire acmd_pkg::acmd_param_wr_t glob_wr_data_o,
	input wire logic irq_glb_en_o,
	input wire logic ctx_restore_o,
	input wire logic reg_re_i,
	input wire logic [31:0] reg_rdata_o
);
	import acmd_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	property p_axis;
		axis_wr_o |-> reply_vld_o && reply_o.status == 8'h64 && reply_o.instr == 8'h22;
	endproperty
	a_axis: assert property (p_axis) else $error("axis write without ok reply");
	property p_axis_sel;
		axis_wr_o |-> axis_wr_data_o.sel <= 8'h05;
	endproperty
	a_axis_sel: assert property (p_axis_sel) else $error("axis write to bad motor");
	property p_glob;
		glob_wr_o |-> reply_vld_o && reply_o.instr == 8'h23 && glob_wr_data_o.sel != 8'h01;
	endproperty
	a_glob: assert property (p_glob) else $error("global write malformed");
	property p_val0;
		reply_vld_o |-> reply_o.value == 32'h0;
	endproperty
	a_val0: assert property (p_val0) else $error("reply value not zero");
	// a reply can only follow a last byte taken two edges before
	property p_lat;
		reply_vld_o |-> $past(byte_vld_i, 2) ##1 !reply_vld_o;
	endproperty
	a_lat: assert property (p_lat) else $error("reply timing wrong");
	property p_ctx;
		ctx_restore_o |-> reply_vld_o && reply_o.instr == 8'h26;
	endproperty
	a_ctx: assert property (p_ctx) else $error("restore without return reply");
	property p_glb_on;
		$rose(irq_glb_en_o) |-> reply_vld_o && reply_o.instr == 8'h19;
	endproperty
	a_glb_on: assert property (p_glb_on) else $error("global enable rose alone");
	// a short mid-run reset would otherwise look like a disable
	property p_glb_off;
		$fell(irq_glb_en_o) && !$past(rst_i) |-> reply_vld_o && reply_o.instr == 8'h1A;
	endproperty
	a_glb_off: assert property (p_glb_off) else $error("global enable fell alone");
	property p_rd0;
		!$past(reg_re_i) |-> reg_rdata_o == 32'h0;
	endproperty
	a_rd0: assert property (p_rd0) else $error("read data outside read slot");
	c_axis: cover property (axis_wr_o);
	c_glob: cover property (glob_wr_o);
	c_ctx: cover property (ctx_restore_o);
endmodule // acmd_exec_monitor

bind acmd_exec acmd_exec_monitor u_acmd_exec_monitor (.clk_sys_i, .rst_i, .byte_vld_i,
	.reply_vld_o, .reply_o, .axis_wr_o, .axis_wr_data_o, .glob_wr_o, .glob_wr_data_o,
	.irq_glb_en_o, .ctx_restore_o, .reg_re_i, .reg_rdata_o);

/* bench/acmd_exec_tb.sv */
`timescale 1ns/10ps
module acmd_exec_tb;
	import acmd_pkg::*;
	logic clk_sys_i = 1'b0, rst_i = 1'b1, reg_we_i = 1'b0, reg_re_i = 1'b0, ctx_save_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00, irq_handler_bind_cmd_idx_i = 8'h03, byte_i;
	logic [31:0] reg_wdata_i = 32'h0, acc_i = 32'hA5C30F12, irq_handler_bind_cmd_label_o, reg_rdata_o;
	logic [4:0] err_set_i = 5'h00, err_flags_o;
	logic byte_vld_i, reply_vld_o, axis_wr_o, glob_wr_o, irq_glb_en_o, irq_handler_bind_cmd_def_o;
	logic ctx_restore_o, irq_o;
	logic [254:0] irq_src_en_o;
	acmd_ctx_t ctx_i = '0, ctx_o;
	acmd_reply_t reply_o;
	acmd_param_wr_t axis_wr_data_o, glob_wr_data_o;
	int n_mismatch = 0, tests_run = 0;
	always #2 clk_sys_i = ~clk_sys_i;
	acmd_host_model u_host (.clk_sys_i, .byte_vld_o(byte_vld_i), .byte_o(byte_i));
	acmd_exec u_acmd_exec (.clk_sys_i, .rst_i, .byte_vld_i, .byte_i, .reply_vld_o, .reply_o,
		.acc_i, .axis_wr_o, .axis_wr_data_o, .glob_wr_o, .glob_wr_data_o, .err_set_i,
		.err_flags_o, .irq_glb_en_o, .irq_src_en_o, .irq_handler_bind_cmd_idx_i, .irq_handler_bind_cmd_label_o, .irq_handler_bind_cmd_def_o,
		.ctx_save_i, .ctx_i, .ctx_restore_o, .ctx_o, .reg_addr_i, .reg_wdata_i, .reg_we_i,
		.reg_re_i, .reg_rdata_o, .irq_o);
	task chk(input logic [127:0] s, e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_we_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_re_i <= 1'b0;
		#1;
		chk(reg_rdata_o, e);
	endtask
	// leaves the caller in the reply cycle so the action strobes can be checked
	task cmd(input logic [7:0] i, t, b, input logic [31:0] v, input logic [7:0] st,
		input logic bad = 1'b0);
		u_host.send({8'h01, i, t, b, v}, bad);
		for (int n = 0; n < 5 && reply_vld_o !== 1'b1; n++) cyc(1);
		chk({reply_vld_o, reply_o.status, reply_o.instr}, {1'b1, st, i});
	endtask
	task test_done;
		if (n_mismatch == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#40000;
		n_mismatch++;
		test_done();
	end
	initial begin
		repeat (12) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		cyc(1);
		chk({irq_o, irq_glb_en_o, err_flags_o}, 0);
		rd(8'h04, 0);
		cmd(8'h22, 8'h07, 8'h05, 32'h1234, 8'h64);
		chk({axis_wr_o, axis_wr_data_o}, {1'b1, 8'h05, 8'h07, acc_i});
		cmd(8'h22, 8'h07, 8'h06, 0, 8'h04);
		chk(axis_wr_o, 0);
		for (int b = 0; b < 4; b++) begin
			cmd(8'h23, 8'h2A, b[7:0], 32'hFFFF, b == 1 ? 8'h04 : 8'h64);
			chk({glob_wr_o, glob_wr_data_o}, {b != 1, (b == 1 ? 8'h00 : b[7:0]), 8'h2A, acc_i});
		end
		for (int t = 1; t < 7; t++) begin
			@(posedge clk_sys_i);
			err_set_i <= 5'h1F;
			@(posedge clk_sys_i);
			err_set_i <= 5'h00;
			cmd(8'h24, t[7:0], 0, 0, t < 6 ? 8'h64 : 8'h03);
			chk(err_flags_o, t < 6 ? 5'(~(5'h01 << (t - 1))) : 5'h1F);
		end
		cmd(8'h24, 0, 0, 0, 8'h64);
		chk(err_flags_o, 0);
		wr(8'h00, 32'hF);
		@(posedge clk_sys_i);
		err_set_i <= 5'h04;
		@(posedge clk_sys_i);
		err_set_i <= 5'h00;
		rd(8'h00, 32'h8);
		chk(irq_o, 0);
		wr(8'h04, 32'h8);
		cyc(2);
		chk(irq_o, 1);
		wr(8'h00, 32'h8);
		wr(8'h08, 0);
		cyc(2);
		chk(irq_o, 0);
		rd(8'h08, 32'h4);
		rd(8'h10, 0);
		cmd(8'h19, 8'hFE, 8'h09, 32'h5, 8'h64);
		chk({irq_glb_en_o, irq_src_en_o[254]}, 2'b01);
		cmd(8'h19, 8'hFF, 0, 0, 8'h64);
		chk({irq_glb_en_o, irq_src_en_o[254]}, 2'b11);
		cmd(8'h1A, 8'hFE, 0, 0, 8'h64);
		chk({irq_glb_en_o, irq_src_en_o[254]}, 2'b10);
		cmd(8'h1A, 8'hFF, 0, 0, 8'h64);
		chk(irq_glb_en_o, 0);
		cmd(8'h25, 8'h03, 0, 32'h32, 8'h64);
		cmd(8'h25, 8'h03, 0, 32'h1C0DE, 8'h64);
		cyc(1);
		chk({irq_handler_bind_cmd_def_o, irq_handler_bind_cmd_label_o}, {1'b1, 32'h1C0DE});
		@(posedge clk_sys_i);
		ctx_i <= {32'h11, 32'h22, 8'h33, 32'h44};
		ctx_save_i <= 1'b1;
		@(posedge clk_sys_i);
		ctx_save_i <= 1'b0;
		ctx_i <= '0;
		cmd(8'h26, 8'hFF, 0, 0, 8'h64);
		chk({ctx_restore_o, ctx_o}, {1'b1, 32'h11, 32'h22, 8'h33, 32'h44});
		cmd(8'h22, 0, 0, 0, 8'h01, 1'b1);
		chk(axis_wr_o, 0);
		cmd(8'h05, 0, 0, 0, 8'h02);
		u_host.send({8'h02, 8'h22, 8'h00, 8'h00, 32'h0}, 1'b0);
		cyc(1);
		chk({reply_vld_o, axis_wr_o}, 0);
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		@(posedge clk_sys_i);
		rst_i <= 1'b0;
		cyc(1);
		chk({irq_o, irq_glb_en_o, irq_handler_bind_cmd_def_o, ctx_o}, 0);
		test_done();
	end
endmodule // acmd_exec_tb

/* bench/acmd_host_model.sv */
`timescale 1ns/10ps
module acmd_host_model (
	// clock
	input wire logic clk_sys_i,
	// byte stream to the device
	output logic byte_vld_o,
	output logic [7:0] byte_o
);
	import acmd_pkg::*;
	initial begin
		byte_vld_o = 1'b0;
		byte_o = 8'h00;
	end
	// bad corrupts the checksum, only when a test wants a refused frame
	task automatic send(input acmd_frame_t f, input logic bad);
		logic [71:0] b;
		b = {f, 8'h00};
		for (int k = 0; k < 8; k++) b[7:0] += b[71-8*k -: 8];
		b[7:0] ^= {8{bad}};
		for (int k = 0; k < 9; k++) begin
			@(posedge clk_sys_i);
			byte_vld_o <= 1'b1;
			byte_o <= b[71-8*k -: 8];
		end
		@(posedge clk_sys_i);
		byte_vld_o <= 1'b0;
		byte_o <= ~b[7:0];
	endtask
endmodule // acmd_host_model

/* hw/acmd_defs.svh */
`ifndef ACMD_DEFS_SVH
`define ACMD_DEFS_SVH

// frame layout
`define ACMD_FRAME_BYTES 4'h9
`define ACMD_LAST_BYTE 4'h8
`define ACMD_MODULE_ADDR 8'h01

// instruction codes
`define ACMD_OP_AXIS_PARAM 8'h22
`define ACMD_OP_GLOBAL_PARAM 8'h23
`define ACMD_OP_CLEAR_ERR 8'h24
`define ACMD_OP_IRQ_UNMASK 8'h19
`define ACMD_OP_IRQ_MASK 8'h1A
`define ACMD_OP_IRQ_BIND 8'h25
`define ACMD_OP_IRQ_RETURN 8'h26

// reply status codes
`define ACMD_ST_OK 8'h64
`define ACMD_ST_BAD_CSUM 8'h01
`define ACMD_ST_BAD_CMD 8'h02
`define ACMD_ST_BAD_TYPE 8'h03
`define ACMD_ST_BAD_VALUE 8'h04

// operand limits and special values
`define ACMD_MOTOR_MAX 8'h05
`define ACMD_IRQ_GLOBAL 8'hFF
`define ACMD_CLE_ALL 8'h00
`define ACMD_CLE_LAST 8'h05

// error flag positions
`define ACMD_ERR_TIMEOUT 0
`define ACMD_ERR_ALARM 1
`define ACMD_ERR_DEVIATION 2
`define ACMD_ERR_POSITION 3
`define ACMD_ERR_SHUTDOWN 4
`define ACMD_ERR_NUM 5

// event status bit positions
`define ACMD_EV_DONE 0
`define ACMD_EV_CSUM 1
`define ACMD_EV_REJECT 2
`define ACMD_EV_ERRFLAG 3
`define ACMD_EV_NUM 4

// register offsets
`define ACMD_REG_EV_STATUS 8'h00
`define ACMD_REG_EV_MASK 8'h04
`define ACMD_REG_ERR_FLAGS 8'h08
`define ACMD_REG_IRQ_STATE 8'h0C

// reset values
`define ACMD_RST_EV_MASK 4'h0
`define ACMD_RST_GLB_EN 1'b0

`endif

/* hw/acmd_exec.sv */
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "acmd_defs.svh"
// Contract
// RL1: code 34 writes accumulator to axis parameter
// RL2: every command answers status 100 on success
// RL3: frame is addr, instr, type, bank, value, checksum
// RL4: code 35 writes accumulator to global parameter
// RL5: code 36 clears error flags chosen by type
// RL6: code 25 enables one interrupt source
// RL7: enable with number 255 sets global enable
// RL8: code 26 disables one interrupt source
// RL9: disable with number 255 clears global enable
// RL10: bind command stores handler label per interrupt
// RL11: later bind overwrites earlier label
// RL12: bind uses code 37, label in value
// RL13: code 38 restores saved context registers
// RL14: checksum is byte sum; bad frames rejected

module acmd_exec (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// host byte stream
	input wire logic byte_vld_i,
	input wire logic [7:0] byte_i,
	// reply to host
	output logic reply_vld_o,
	output acmd_pkg::acmd_reply_t reply_o,
	// accumulator and parameter writes
	input wire logic [31:0] acc_i,
	output logic axis_wr_o,
	output acmd_pkg::acmd_param_wr_t axis_wr_data_o,
	output logic glob_wr_o,
	output acmd_pkg::acmd_param_wr_t glob_wr_data_o,
	// error flag sources
	input wire logic [4:0] err_set_i,
	output logic [4:0] err_flags_o,
	// interrupt enables and vectors
	output logic irq_glb_en_o,
	output logic [254:0] irq_src_en_o,
	input wire logic [7:0] irq_handler_bind_cmd_idx_i,
	output logic [31:0] irq_handler_bind_cmd_label_o,
	output logic irq_handler_bind_cmd_def_o,
	// handler context
	input wire logic ctx_save_i,
	input wire acmd_pkg::acmd_ctx_t ctx_i,
	output logic ctx_restore_o,
	output acmd_pkg::acmd_ctx_t ctx_o,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	// interrupt to software
	output logic irq_o
);
	import acmd_pkg::*;

	// every register but the handler label table and its read register in one word, so reset and update live in one place
	typedef struct packed {
		logic reply_vld;
		acmd_reply_t reply;
		logic axis_wr;
		acmd_param_wr_t axis_wr_data;
		logic glob_wr;
		acmd_param_wr_t glob_wr_data;
		logic [4:0] err_flags;
		logic glb_en;
		// numbers 0 to 254 have a source enable; 255 only names the global one
		logic [254:0] src_en;
		// a bit per number tells an unbound entry from one bound to label 0
		logic [255:0] irq_handler_bind_cmd_def;
		logic irq_handler_bind_cmd_def_rd;
		acmd_ctx_t ctx;
		logic ctx_restore;
		logic [3:0] ev_status;
		logic [3:0] ev_mask;
		logic [31:0] rdata;
		logic irq;
	} acmd_exec_q_t;

	acmd_exec_q_t q;
	acmd_exec_q_t next_q;

	logic frm_vld;
	logic frm_ok;
	acmd_frame_t frm;

	// handler labels live in a plain array so synthesis can map them to ram
	logic [31:0] irq_handler_bind_cmd_tab [0:255];
	// no reset on the table: a label read before its first bind is undefined
	logic [31:0] irq_handler_bind_cmd_label;
	logic irq_handler_bind_cmd_we;
	logic [7:0] irq_handler_bind_cmd_waddr;
	logic [31:0] irq_handler_bind_cmd_wdata;

	logic [3:0] ev_set;
	logic [3:0] ev_clr;
	logic [4:0] err_clr;

	function automatic acmd_reply_t mk_reply(input logic [7:0] st, input logic [7:0] op);
		acmd_reply_t r;
		r.status = st;
		r.instr = op;
		// the value field carries nothing for this command group
		r.value = 32'h0000_0000; // RL2
		return r;
	endfunction

	function automatic logic bank_ok(input logic [7:0] b);
		return (b == 8'h00) || (b == 8'h02) || (b == 8'h03);
	endfunction

	// the motor byte of an axis write picks one of the six axes
	function automatic logic motor_ok(input logic [7:0] m);
		return m <= `ACMD_MOTOR_MAX;
	endfunction

	// number 255 names no source; it only moves the global enable
	function automatic logic is_global(input logic [7:0] n);
		return n == `ACMD_IRQ_GLOBAL;
	endfunction

	// clear-flags type: 0 picks every flag, n picks flag n-1
	function automatic logic [4:0] clr_mask(input logic [7:0] t);
		logic [4:0] m;
		m = 5'h00;
		case (t)
			`ACMD_CLE_ALL: m = 5'h1F;
			8'h01: m[`ACMD_ERR_TIMEOUT] = 1'b1;
			8'h02: m[`ACMD_ERR_ALARM] = 1'b1;
			8'h03: m[`ACMD_ERR_DEVIATION] = 1'b1;
			8'h04: m[`ACMD_ERR_POSITION] = 1'b1;
			8'h05: m[`ACMD_ERR_SHUTDOWN] = 1'b1;
			default: m = 5'h00;
		endcase
		return m;
	endfunction

	// one event per answered frame: done when accepted, csum on a bad checksum, reject otherwise
	function automatic logic [3:0] frame_event(input logic [7:0] st);
		logic [3:0] e;
		e = 4'h0;
		case (st)
			`ACMD_ST_OK: e[`ACMD_EV_DONE] = 1'b1;
			`ACMD_ST_BAD_CSUM: e[`ACMD_EV_CSUM] = 1'b1;
			default: e[`ACMD_EV_REJECT] = 1'b1;
		endcase
		return e;
	endfunction

	// read mux of the register port; unmapped offsets read zero
	function automatic logic [31:0] reg_read(input logic [7:0] a, input acmd_exec_q_t s);
		logic [31:0] d;
		d = 32'h0000_0000;
		case (a)
			`ACMD_REG_EV_STATUS: d[3:0] = s.ev_status;
			`ACMD_REG_EV_MASK: d[3:0] = s.ev_mask;
			`ACMD_REG_ERR_FLAGS: d[4:0] = s.err_flags;
			`ACMD_REG_IRQ_STATE: d[0] = s.glb_en;
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction

	// sticky update shared by status and error flags: a set in the clear cycle wins
	function automatic logic [4:0] sticky(input logic [4:0] cur, input logic [4:0] clr,
		input logic [4:0] set);
		return (cur & ~clr) | set;
	endfunction

	function automatic acmd_param_wr_t mk_wr(input logic [7:0] s, input logic [7:0] i,
		input logic [31:0] d);
		acmd_param_wr_t w;
		w.sel = s;
		w.index = i;
		w.data = d;
		return w;
	endfunction

	// frames arrive assembled and checksum-checked, one cycle after their last byte
	acmd_frame_rx u_rx (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.byte_vld_i(byte_vld_i),
		.byte_i(byte_i),
		.frm_vld_o(frm_vld),
		.frm_ok_o(frm_ok),
		.frm_o(frm)
	);

	always_comb begin
		// strobes default low; read data is zeroed below unless read; every other register holds
		next_q = q;
		next_q.reply_vld = 1'b0;
		next_q.axis_wr = 1'b0;
		next_q.glob_wr = 1'b0;
		next_q.ctx_restore = 1'b0;
		ev_set = 4'h0;
		err_clr = 5'h00;
		ev_clr = 4'h0;
		irq_handler_bind_cmd_we = 1'b0;
		irq_handler_bind_cmd_waddr = frm.ptype;
		irq_handler_bind_cmd_wdata = frm.value;

		// frames for another module address are dropped without a reply
		if (frm_vld && (frm.addr == `ACMD_MODULE_ADDR)) begin
			next_q.reply_vld = 1'b1;
			next_q.reply = mk_reply(`ACMD_ST_OK, frm.instr); // RL2
			if (!frm_ok) begin
				// a corrupted frame moves no state; it only reports itself
				next_q.reply = mk_reply(`ACMD_ST_BAD_CSUM, frm.instr); // RL14
			end else begin
				case (frm.instr)
					`ACMD_OP_AXIS_PARAM: begin
						// the accumulator is taken in the execute cycle; value bytes unused
						if (motor_ok(frm.bank)) begin
							next_q.axis_wr = 1'b1; // RL1
							next_q.axis_wr_data = mk_wr(frm.bank, frm.ptype, acc_i); // RL1
						end else begin
							next_q.reply = mk_reply(`ACMD_ST_BAD_VALUE, frm.instr);
						end
					end
					`ACMD_OP_GLOBAL_PARAM: begin
						// value bytes are ignored; the data is the accumulator
						if (bank_ok(frm.bank)) begin
							next_q.glob_wr = 1'b1; // RL4
							next_q.glob_wr_data = mk_wr(frm.bank, frm.ptype, acc_i); // RL4
						end else begin
							next_q.reply = mk_reply(`ACMD_ST_BAD_VALUE, frm.instr);
						end
					end
					`ACMD_OP_CLEAR_ERR: begin
						if (frm.ptype <= `ACMD_CLE_LAST) begin
							err_clr = clr_mask(frm.ptype); // RL5
						end else begin
							next_q.reply = mk_reply(`ACMD_ST_BAD_TYPE, frm.instr);
						end
					end
					`ACMD_OP_IRQ_UNMASK: begin
						if (is_global(frm.ptype)) begin
							next_q.glb_en = 1'b1; // RL7
						end else begin
							next_q.src_en[frm.ptype] = 1'b1; // RL6
						end
					end
					`ACMD_OP_IRQ_MASK: begin
						if (is_global(frm.ptype)) begin
							next_q.glb_en = 1'b0; // RL9
						end else begin
							next_q.src_en[frm.ptype] = 1'b0; // RL8
						end
					end
					`ACMD_OP_IRQ_BIND: begin
						// no guard on an existing entry: the newest label wins
						irq_handler_bind_cmd_we = 1'b1; // RL10 RL11 RL12
						next_q.irq_handler_bind_cmd_def[frm.ptype] = 1'b1; // RL10
					end
					`ACMD_OP_IRQ_RETURN: begin
						next_q.ctx_restore = 1'b1; // RL13
					end
					default: begin
						next_q.reply = mk_reply(`ACMD_ST_BAD_CMD, frm.instr);
					end
				endcase
			end
			ev_set = frame_event(next_q.reply.status);
		end

		// handler entry saves the running context for a later return
		// a return with no save before it restores whatever was stored last
		if (ctx_save_i) begin
			next_q.ctx = ctx_i;
		end

		// a flag raised in the same cycle as its clear stays set
		next_q.err_flags = sticky(q.err_flags, err_clr, err_set_i); // RL5
		if (|(err_set_i & ~q.err_flags)) begin
			ev_set[`ACMD_EV_ERRFLAG] = 1'b1;
		end

		// register port; read data is valid the cycle after the strobe
		// and zero otherwise, so read words of several blocks can be or-ed
		next_q.rdata = 32'h0000_0000;
		if (reg_we_i) begin
			case (reg_addr_i)
				`ACMD_REG_EV_STATUS: ev_clr = reg_wdata_i[3:0];
				`ACMD_REG_EV_MASK: next_q.ev_mask = reg_wdata_i[3:0];
				// flag and enable words are read-only; writes to them are dropped
				`ACMD_REG_ERR_FLAGS, `ACMD_REG_IRQ_STATE: begin
				end
				default: begin
				end
			endcase
		end
		next_q.ev_status = 4'(sticky({1'b0, q.ev_status}, {1'b0, ev_clr}, {1'b0, ev_set}));
		if (reg_re_i) begin
			next_q.rdata = reg_read(reg_addr_i, q);
		end

		// irq follows the registered status, so a bus write cannot make it glitch
		next_q.irq = |(next_q.ev_status & next_q.ev_mask);
		// the defined flag is read a cycle late to line up with the label from ram
		next_q.irq_handler_bind_cmd_def_rd = q.irq_handler_bind_cmd_def[irq_handler_bind_cmd_idx_i];
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			q <= '0;
			q.glb_en <= `ACMD_RST_GLB_EN;
			q.ev_mask <= `ACMD_RST_EV_MASK;
		end else begin
			q <= next_q;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (irq_handler_bind_cmd_we) begin
			irq_handler_bind_cmd_tab[irq_handler_bind_cmd_waddr] <= irq_handler_bind_cmd_wdata; // RL11
		end
		irq_handler_bind_cmd_label <= irq_handler_bind_cmd_tab[irq_handler_bind_cmd_idx_i];
	end

	assign reply_vld_o = q.reply_vld;
	assign reply_o = q.reply;
	assign axis_wr_o = q.axis_wr;
	assign axis_wr_data_o = q.axis_wr_data;
	assign glob_wr_o = q.glob_wr;
	assign glob_wr_data_o = q.glob_wr_data;
	assign err_flags_o = q.err_flags;
	assign irq_glb_en_o = q.glb_en;
	assign irq_src_en_o = q.src_en;
	assign irq_handler_bind_cmd_label_o = irq_handler_bind_cmd_label;
	assign irq_handler_bind_cmd_def_o = q.irq_handler_bind_cmd_def_rd;
	assign ctx_restore_o = q.ctx_restore;
	assign ctx_o = q.ctx;
	assign reg_rdata_o = q.rdata;
	assign irq_o = q.irq;

endmodule // acmd_exec

/* hw/acmd_frame_rx.sv */
`timescale 1ns/10ps
`include "acmd_defs.svh"

module acmd_frame_rx (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// byte stream from the host link
	input wire logic byte_vld_i,
	input wire logic [7:0] byte_i,
	// assembled frame
	output logic frm_vld_o,
	output logic frm_ok_o,
	output acmd_pkg::acmd_frame_t frm_o
);
	import acmd_pkg::*;

	typedef struct packed {
		acmd_rx_state_t st;
		logic [3:0] cnt;
		logic [7:0] sum;
		acmd_frame_t frm;
		logic vld;
		logic ok;
	} acmd_rx_q_t;

	acmd_rx_q_t q;
	acmd_rx_q_t next_q;

	always_comb begin
		next_q = q;
		next_q.vld = 1'b0;
		case (q.st)
			ACMD_RX_IDLE, ACMD_RX_DONE: begin
				next_q.st = ACMD_RX_IDLE;
				if (byte_vld_i) begin
					next_q.st = ACMD_RX_BODY;
					next_q.cnt = 4'h1;
					next_q.sum = byte_i;
					next_q.frm.addr = byte_i; // RL3
				end
			end
			ACMD_RX_BODY: begin
				if (byte_vld_i) begin
					next_q.cnt = q.cnt + 4'h1;
					next_q.sum = q.sum + byte_i; // RL14
					case (q.cnt)
						4'h1: next_q.frm.instr = byte_i; // RL3
						4'h2: next_q.frm.ptype = byte_i;
						4'h3: next_q.frm.bank = byte_i;
						// value arrives most significant byte first
						4'h4: next_q.frm.value[31:24] = byte_i; // RL3
						4'h5: next_q.frm.value[23:16] = byte_i;
						4'h6: next_q.frm.value[15:8] = byte_i;
						4'h7: next_q.frm.value[7:0] = byte_i;
						default: begin
							next_q.st = ACMD_RX_DONE;
							next_q.vld = 1'b1;
							next_q.ok = (q.sum == byte_i); // RL14
						end
					endcase
				end
			end
			default: next_q.st = ACMD_RX_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			q <= '0;
			q.st <= ACMD_RX_IDLE;
		end else begin
			q <= next_q;
		end
	end

	assign frm_vld_o = q.vld;
	assign frm_ok_o = q.ok;
	assign frm_o = q.frm;

endmodule // acmd_frame_rx

/* hw/acmd_pkg.sv */
package acmd_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] instr;
		logic [7:0] ptype;
		logic [7:0] bank;
		logic [31:0] value;
	} acmd_frame_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] instr;
		logic [31:0] value;
	} acmd_reply_t;

	typedef struct packed {
		logic [7:0] sel;
		logic [7:0] index;
		logic [31:0] data;
	} acmd_param_wr_t;

	typedef struct packed {
		logic [31:0] acc;
		logic [31:0] xreg;
		logic [7:0] flags;
		logic [31:0] pc;
	} acmd_ctx_t;

	typedef enum logic [2:0] {
		ACMD_RX_IDLE = 3'b001,
		ACMD_RX_BODY = 3'b010,
		ACMD_RX_DONE = 3'b100
	} acmd_rx_state_t;

endpackage
